// file: rtl/eprgbt_defs.svh
// register map, field positions, reset values and timing counts
`ifndef EPRGBT_DEFS_SVH
`define EPRGBT_DEFS_SVH
`define EPRGBT_STAT_OFS 8'h00
`define EPRGBT_CTRL_OFS 8'h1C
`define EPRGBT_LAT_BIT 1
`define EPRGBT_PULSE_BIT 0
`define EPRGBT_CTRL_RST 2'h0
`define EPRGBT_ERASED 8'h00
`define EPRGBT_LAST_ADDR 14'h3FFF
`define EPRGBT_BOOT_VEC_LO 14'h3FE4
`define EPRGBT_BOOT_VEC_HI 14'h3FEF
`define EPRGBT_BOOT_VEC_MAX 3'h5
`define EPRGBT_USER_VEC_LO 14'h3FF0
`define EPRGBT_PSEUDO_BASE 14'h00E0
`define EPRGBT_PSEUDO_LEN 14'h0003
`define EPRGBT_RAM_JUMP 14'h0081
`define EPRGBT_CLK_MHZ 50
`define EPRGBT_PULSE_TIME_US 1000
`define EPRGBT_PULSE_CYC (`EPRGBT_PULSE_TIME_US * `EPRGBT_CLK_MHZ)
`define EPRGBT_SETTLE_CYC 20'h00006
`define EPRGBT_RESP_OKAY 2'h0
`define EPRGBT_RESP_SLVERR 2'h2
`endif

// file: rtl/eprgbt_pkg.sv
// types shared by the eprom programming and boot mode block
package eprgbt_pkg;
    typedef enum logic [2:0] {
        MODE_SINGLE, MODE_EP_VERIFY, MODE_EP_PROGRAM, MODE_RAM_JUMP, MODE_RAM_LOAD
    } eprgbt_mode_t;
    typedef enum logic [3:0] {
        E_IDLE, E_PRST, E_PSETTLE, E_PLATCH, E_PWRITE, E_PPULSE, E_PCLR, E_PADV,
        E_VRST, E_VSETTLE, E_VCMP, E_VADV, E_DONE
    } eprgbt_eng_t;
    typedef struct packed {
        logic [13:0] addr;
        logic [7:0] wdata;
        logic rd_en;
        logic power;
    } eprgbt_arr_t;
    typedef struct packed {
        logic clk;
        logic rst;
    } eprgbt_cnt_t;
    typedef struct packed {
        logic programming_indicator;
        logic verify_match_indicator;
    } eprgbt_led_t;
endpackage

// file: rtl/eprgbt_top.sv
// eprom programming control, boot mode selection and on-chip bootloader engine
//
// Overview of operation
// [RULE1] test voltage absent at reset release: single chip, port B straps ignored
// [RULE2] test voltage, bit 6 high, bit 2 low: eprom boot; bit 3 picks verify/program
// [RULE3] test voltage, bit 2 high: ram boot; bit 3 low jumps to $81, high loads (code also requires bit 6 high, else single chip)
// [RULE4] boot modes take vectors from reserved rom $3FE4 to $3FEF
// [RULE5] single chip takes all vectors from the on-chip eprom
// [RULE6] engine drives clock and reset of the external 14-bit address counter
// [RULE7] boot vectors redirect to three-byte ram pseudo-vectors
// [RULE8] eprom boot copies external image in, then verifies in a second pass (code copies only with bit 3 high; bit 3 low runs verify alone)
// [RULE9] programming indicator on while programming, off once finished
// [RULE10] verify indicator lit only on exact match; mismatch leaves both off
// [RULE11] control register at $1C: latch enable bit 1, pulse bit 0 resets 0
// [RULE12] latch set: eprom writes capture address and data, reads unavailable
// [RULE13] pulse settable only with latch already set; cleared when latch is 0
// [RULE14] one write never sets latch and pulse together
// [RULE15] software: latch, write byte, hold pulse for the pulse time, clear both
// [RULE16] erased locations read $00
// [RULE17] operator erases the eprom before programming
// [RULE18] writes to upper six control bits do nothing; they read as zero
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`include "eprgbt_defs.svh"

module eprgbt_top #(
    parameter int unsigned PULSE_CYCLES = `EPRGBT_PULSE_CYC
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // strap pins
    input wire logic test_mode_voltage,
    input wire logic port_b_bit_two,
    input wire logic port_b_bit_three,
    input wire logic port_b_bit_six_in,
    // cpu eprom port
    input wire logic cpu_ep_wr,
    input wire logic cpu_ep_rd,
    input wire logic [13:0] cpu_ep_addr,
    input wire logic [7:0] cpu_ep_wdata,
    output logic [7:0] cpu_ep_rdata,
    // vector fetch
    input wire logic cpu_vec_fetch,
    input wire logic [2:0] cpu_vec_idx,
    output logic [13:0] vector_addr,
    output logic [13:0] pseudo_vec_addr,
    output logic [13:0] ram_entry_addr,
    // eprom array
    output eprgbt_pkg::eprgbt_arr_t arr,
    input wire logic [7:0] arr_rdata,
    // external counter and image data
    output eprgbt_pkg::eprgbt_cnt_t ext_cnt,
    input wire logic [7:0] ext_data,
    // indicator pins, port b bits one and six
    output eprgbt_pkg::eprgbt_led_t led,
    output logic led_oe
);

    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
        reg_hit = (a[7:2] == ofs[7:2]);
    endfunction

    function automatic eprgbt_pkg::eprgbt_mode_t mode_dec(input logic [3:0] s);
        if (!s[3] || !s[0]) begin
            mode_dec = eprgbt_pkg::MODE_SINGLE;
        end else if (!s[2]) begin
            mode_dec = s[1] ? eprgbt_pkg::MODE_EP_PROGRAM : eprgbt_pkg::MODE_EP_VERIFY;
        end else begin
            mode_dec = s[1] ? eprgbt_pkg::MODE_RAM_LOAD : eprgbt_pkg::MODE_RAM_JUMP;
        end
    endfunction

    // ==========================================================
    // pin synchronisers
    // left without reset so they already hold the straps when reset lifts
    logic [3:0] strap_m_ff, strap_s_ff;
    logic [7:0] ext_m_ff, ext_s_ff;
    always_ff @(posedge aclk) begin
        if (ce) begin
            strap_m_ff <= {test_mode_voltage, port_b_bit_two, port_b_bit_three, port_b_bit_six_in};
            strap_s_ff <= strap_m_ff;
            ext_m_ff <= ext_data;
            ext_s_ff <= ext_m_ff;
        end
    end

    // ==========================================================
    // mode capture at reset release
    eprgbt_pkg::eprgbt_mode_t mode_ff;
    logic mode_taken_ff;
    logic boot_mode, ep_boot;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_ff <= eprgbt_pkg::MODE_SINGLE;
            mode_taken_ff <= 1'b0;
            ram_entry_addr <= 14'h0000;
        end else if (ce && !mode_taken_ff) begin
            mode_ff <= mode_dec(strap_s_ff); // [RULE1] [RULE2] [RULE3]
            mode_taken_ff <= 1'b1;
            if (mode_dec(strap_s_ff) == eprgbt_pkg::MODE_RAM_JUMP) begin
                ram_entry_addr <= `EPRGBT_RAM_JUMP; // [RULE3]
            end
        end
    end
    assign boot_mode = (mode_ff != eprgbt_pkg::MODE_SINGLE);
    assign ep_boot = (mode_ff == eprgbt_pkg::MODE_EP_VERIFY)
        || (mode_ff == eprgbt_pkg::MODE_EP_PROGRAM);

    // ==========================================================
    // axi4-lite slave handshakes
    logic aw_hold_ff, w_hold_ff;
    logic [7:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic aw_hs, w_hs, do_wr, ctrl_wr;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    assign awready = ce && !aw_hold_ff && !bvalid;
    assign wready = ce && !w_hold_ff && !bvalid;
    assign aw_hs = awvalid && awready;
    assign w_hs = wvalid && wready;
    assign do_wr = (aw_hold_ff || aw_hs) && (w_hold_ff || w_hs);
    assign wr_addr = aw_hold_ff ? aw_addr_ff : awaddr;
    assign wr_data = w_hold_ff ? w_data_ff : wdata;
    assign wr_strb = w_hold_ff ? w_strb_ff : wstrb;
    assign ctrl_wr = do_wr && reg_hit(wr_addr, `EPRGBT_CTRL_OFS) && wr_strb[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `EPRGBT_RESP_OKAY;
        end else if (ce) begin
            if (do_wr) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (reg_hit(wr_addr, `EPRGBT_CTRL_OFS) || reg_hit(wr_addr, `EPRGBT_STAT_OFS))
                    ? `EPRGBT_RESP_OKAY : `EPRGBT_RESP_SLVERR;
            end else begin
                if (aw_hs) begin
                    aw_hold_ff <= 1'b1;
                    aw_addr_ff <= awaddr;
                end
                if (w_hs) begin
                    w_hold_ff <= 1'b1;
                    w_data_ff <= wdata;
                    w_strb_ff <= wstrb;
                end
                if (bvalid && bready) begin
                    bvalid <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // bootloader engine
    eprgbt_pkg::eprgbt_eng_t state_ff;
    logic [19:0] wait_ff;
    logic [13:0] eng_addr_ff;
    logic [7:0] eng_data_ff;
    logic mismatch_ff, busy, eng_wr, lat_want, pulse_want, program_phase;
    logic [1:0] ctrl_ff;
    assign busy = (state_ff != eprgbt_pkg::E_IDLE) && (state_ff != eprgbt_pkg::E_DONE);
    assign eng_wr = (state_ff == eprgbt_pkg::E_PWRITE);
    // latch goes up one state early so the write state already captures the byte
    assign lat_want = (state_ff == eprgbt_pkg::E_PLATCH) || (state_ff == eprgbt_pkg::E_PWRITE)
        || (state_ff == eprgbt_pkg::E_PPULSE); // [RULE12]
    assign pulse_want = (state_ff == eprgbt_pkg::E_PPULSE);
    assign program_phase = (state_ff >= eprgbt_pkg::E_PRST) && (state_ff <= eprgbt_pkg::E_PADV);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= eprgbt_pkg::E_IDLE;
            wait_ff <= 20'h00000;
            eng_addr_ff <= 14'h0000;
            eng_data_ff <= 8'h00;
            mismatch_ff <= 1'b0;
        end else if (ce) begin
            unique case (state_ff)
                eprgbt_pkg::E_IDLE: begin
                    if (mode_taken_ff && mode_ff == eprgbt_pkg::MODE_EP_PROGRAM) begin
                        state_ff <= eprgbt_pkg::E_PRST; // [RULE8]
                    end else if (mode_taken_ff && mode_ff == eprgbt_pkg::MODE_EP_VERIFY) begin
                        state_ff <= eprgbt_pkg::E_VRST;
                    end
                end
                eprgbt_pkg::E_PRST: begin
                    eng_addr_ff <= 14'h0000;
                    wait_ff <= 20'h00000;
                    state_ff <= eprgbt_pkg::E_PSETTLE;
                end
                eprgbt_pkg::E_PSETTLE: begin
                    wait_ff <= wait_ff + 20'h00001;
                    if (wait_ff == `EPRGBT_SETTLE_CYC - 20'h00001) begin
                        eng_data_ff <= ext_s_ff;
                        // erased bytes already hold the image value
                        state_ff <= (ext_s_ff == `EPRGBT_ERASED) ? eprgbt_pkg::E_PADV
                            : eprgbt_pkg::E_PLATCH; // [RULE16]
                    end
                end
                eprgbt_pkg::E_PLATCH: state_ff <= eprgbt_pkg::E_PWRITE;
                eprgbt_pkg::E_PWRITE: begin
                    wait_ff <= 20'h00000;
                    state_ff <= eprgbt_pkg::E_PPULSE;
                end
                eprgbt_pkg::E_PPULSE: begin
                    wait_ff <= wait_ff + 20'h00001;
                    if (wait_ff == 20'(PULSE_CYCLES - 1)) begin
                        state_ff <= eprgbt_pkg::E_PCLR;
                    end
                end
                eprgbt_pkg::E_PCLR: state_ff <= eprgbt_pkg::E_PADV;
                eprgbt_pkg::E_PADV: begin
                    eng_addr_ff <= eng_addr_ff + 14'h0001;
                    wait_ff <= 20'h00000;
                    state_ff <= (eng_addr_ff == `EPRGBT_LAST_ADDR) ? eprgbt_pkg::E_VRST
                        : eprgbt_pkg::E_PSETTLE; // [RULE8]
                end
                eprgbt_pkg::E_VRST: begin
                    eng_addr_ff <= 14'h0000;
                    wait_ff <= 20'h00000;
                    state_ff <= eprgbt_pkg::E_VSETTLE;
                end
                eprgbt_pkg::E_VSETTLE: begin
                    wait_ff <= wait_ff + 20'h00001;
                    if (wait_ff == `EPRGBT_SETTLE_CYC - 20'h00001) begin
                        state_ff <= eprgbt_pkg::E_VCMP;
                    end
                end
                eprgbt_pkg::E_VCMP: begin
                    if (arr_rdata != ext_s_ff) begin
                        mismatch_ff <= 1'b1; // [RULE10]
                    end
                    state_ff <= eprgbt_pkg::E_VADV;
                end
                eprgbt_pkg::E_VADV: begin
                    eng_addr_ff <= eng_addr_ff + 14'h0001;
                    wait_ff <= 20'h00000;
                    state_ff <= (eng_addr_ff == `EPRGBT_LAST_ADDR) ? eprgbt_pkg::E_DONE
                        : eprgbt_pkg::E_VSETTLE;
                end
                eprgbt_pkg::E_DONE: state_ff <= eprgbt_pkg::E_DONE;
            endcase
        end
    end

    // counter strobes registered; the settle wait covers this lag plus the synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_cnt <= '0;
            led <= '0;
        end else if (ce) begin
            ext_cnt.clk <= (state_ff == eprgbt_pkg::E_PADV)
                || (state_ff == eprgbt_pkg::E_VADV); // [RULE6]
            ext_cnt.rst <= (state_ff == eprgbt_pkg::E_PRST)
                || (state_ff == eprgbt_pkg::E_VRST); // [RULE6]
            led.programming_indicator <= program_phase; // [RULE9]
            led.verify_match_indicator <= (state_ff == eprgbt_pkg::E_DONE)
                && !mismatch_ff; // [RULE10]
        end
    end
    assign led_oe = ep_boot;

    // ==========================================================
    // programming control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= `EPRGBT_CTRL_RST; // [RULE11]
        end else if (ce) begin
            if (busy) begin
                // engine owns the register while it runs; bus writes are dropped
                ctrl_ff[`EPRGBT_LAT_BIT] <= lat_want;
                ctrl_ff[`EPRGBT_PULSE_BIT] <= pulse_want && ctrl_ff[`EPRGBT_LAT_BIT]; // [RULE13]
            end else if (ctrl_wr) begin
                // only bits 1:0 are kept, upper data bits are dropped [RULE18]
                ctrl_ff[`EPRGBT_LAT_BIT] <= wr_data[`EPRGBT_LAT_BIT];
                ctrl_ff[`EPRGBT_PULSE_BIT] <= wr_data[`EPRGBT_PULSE_BIT]
                    && wr_data[`EPRGBT_LAT_BIT] && ctrl_ff[`EPRGBT_LAT_BIT]; // [RULE13] [RULE14]
            end else if (!ctrl_ff[`EPRGBT_LAT_BIT]) begin
                ctrl_ff[`EPRGBT_PULSE_BIT] <= 1'b0; // [RULE13]
            end
        end
    end

    // ==========================================================
    // eprom array access
    logic [13:0] lat_addr_ff;
    logic [7:0] lat_data_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lat_addr_ff <= 14'h0000;
            lat_data_ff <= 8'h00;
            cpu_ep_rdata <= 8'h00;
        end else if (ce) begin
            if (ctrl_ff[`EPRGBT_LAT_BIT] && (eng_wr || cpu_ep_wr)) begin
                lat_addr_ff <= eng_wr ? eng_addr_ff : cpu_ep_addr; // [RULE12]
                lat_data_ff <= eng_wr ? eng_data_ff : cpu_ep_wdata; // [RULE12]
            end
            if (cpu_ep_rd) begin
                cpu_ep_rdata <= ctrl_ff[`EPRGBT_LAT_BIT] ? `EPRGBT_ERASED : arr_rdata; // [RULE12]
            end
        end
    end
    assign arr.addr = ctrl_ff[`EPRGBT_LAT_BIT] ? lat_addr_ff : (busy ? eng_addr_ff : cpu_ep_addr);
    assign arr.wdata = lat_data_ff;
    assign arr.rd_en = !ctrl_ff[`EPRGBT_LAT_BIT]; // [RULE12]
    assign arr.power = ctrl_ff[`EPRGBT_PULSE_BIT]; // [RULE13]

    // ==========================================================
    // vector redirection
    logic [2:0] vidx;
    assign vidx = (cpu_vec_idx > `EPRGBT_BOOT_VEC_MAX) ? `EPRGBT_BOOT_VEC_MAX : cpu_vec_idx;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vector_addr <= 14'h0000;
            pseudo_vec_addr <= 14'h0000;
        end else if (ce && cpu_vec_fetch) begin
            if (boot_mode) begin
                vector_addr <= `EPRGBT_BOOT_VEC_LO + {10'h000, vidx, 1'b0}; // [RULE4]
                pseudo_vec_addr <= `EPRGBT_PSEUDO_BASE
                    + `EPRGBT_PSEUDO_LEN * {11'h000, vidx}; // [RULE7]
            end else begin
                vector_addr <= `EPRGBT_USER_VEC_LO + {10'h000, cpu_vec_idx, 1'b0}; // [RULE5]
                pseudo_vec_addr <= 14'h0000;
            end
        end
    end

    // ==========================================================
    // axi4-lite read
    assign arready = ce && !rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `EPRGBT_RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp <= `EPRGBT_RESP_OKAY;
                if (reg_hit(araddr, `EPRGBT_CTRL_OFS)) begin
                    rdata <= {30'h00000000, ctrl_ff}; // [RULE18]
                end else if (reg_hit(araddr, `EPRGBT_STAT_OFS)) begin
                    rdata <= {22'h000000, mismatch_ff, state_ff == eprgbt_pkg::E_DONE,
                        led.verify_match_indicator, led.programming_indicator, busy,
                        mode_taken_ff, 1'b0, mode_ff};
                end else begin
                    rdata <= 32'h00000000;
                    rresp <= `EPRGBT_RESP_SLVERR;
                end
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // assertions
    property p_single_chip;
        @(posedge aclk) disable iff (!aresetn)
        ce && !mode_taken_ff && !strap_s_ff[3] |=> mode_ff == eprgbt_pkg::MODE_SINGLE;
    endproperty
    a_single_chip: assert property (p_single_chip) else $error("single chip not taken"); // [RULE1]

    property p_boot_vec;
        @(posedge aclk) disable iff (!aresetn)
        ce && cpu_vec_fetch && boot_mode
        |=> vector_addr inside {[`EPRGBT_BOOT_VEC_LO:`EPRGBT_BOOT_VEC_HI]};
    endproperty
    a_boot_vec: assert property (p_boot_vec) else $error("boot vector outside rom"); // [RULE4]

    property p_pseudo;
        @(posedge aclk) disable iff (!aresetn)
        ce && cpu_vec_fetch && boot_mode && cpu_vec_idx <= `EPRGBT_BOOT_VEC_MAX
        |=> pseudo_vec_addr == `EPRGBT_PSEUDO_BASE + 14'h0003 * {11'h000, $past(cpu_vec_idx)};
    endproperty
    a_pseudo: assert property (p_pseudo) else $error("pseudo vector stride wrong"); // [RULE7]

    property p_cnt_clk;
        @(posedge aclk) disable iff (!aresetn)
        ce && state_ff == eprgbt_pkg::E_PADV |=> ext_cnt.clk && !ext_cnt.rst;
    endproperty
    a_cnt_clk: assert property (p_cnt_clk) else $error("counter clock missing"); // [RULE6]

    property p_pass_order;
        @(posedge aclk) disable iff (!aresetn)
        $rose(state_ff == eprgbt_pkg::E_VRST) && mode_ff == eprgbt_pkg::MODE_EP_PROGRAM
        |-> $past(state_ff) == eprgbt_pkg::E_PADV && $past(eng_addr_ff) == `EPRGBT_LAST_ADDR;
    endproperty
    a_pass_order: assert property (p_pass_order) else $error("verify before program end"); // [RULE8]

    property p_led_program;
        @(posedge aclk) disable iff (!aresetn)
        ce && state_ff == eprgbt_pkg::E_PPULSE |=> led.programming_indicator;
    endproperty
    a_led_program: assert property (p_led_program) else $error("program led off"); // [RULE9]

    property p_led_verify;
        @(posedge aclk) disable iff (!aresetn)
        led.verify_match_indicator |-> !mismatch_ff && !led.programming_indicator;
    endproperty
    a_led_verify: assert property (p_led_verify) else $error("verify led on mismatch"); // [RULE10]

    property p_latch_read;
        @(posedge aclk) disable iff (!aresetn)
        ce && cpu_ep_rd && ctrl_ff[`EPRGBT_LAT_BIT] |=> cpu_ep_rdata == `EPRGBT_ERASED;
    endproperty
    a_latch_read: assert property (p_latch_read) else $error("read during latch"); // [RULE12]

    property p_pulse_rise;
        @(posedge aclk) disable iff (!aresetn)
        $rose(ctrl_ff[`EPRGBT_PULSE_BIT]) |-> $past(ctrl_ff[`EPRGBT_LAT_BIT]);
    endproperty
    a_pulse_rise: assert property (p_pulse_rise) else $error("pulse without latch"); // [RULE13]

    property p_one_write;
        @(posedge aclk) disable iff (!aresetn)
        ce && ctrl_wr && !busy && !ctrl_ff[`EPRGBT_LAT_BIT] |=> !ctrl_ff[`EPRGBT_PULSE_BIT];
    endproperty
    a_one_write: assert property (p_one_write) else $error("both bits set at once"); // [RULE14]

endmodule

// file: sim/eprgbt_ext_eprom.sv
// model of the external address counter and the image eprom behind it
`timescale 1ns/1ns
module eprgbt_ext_eprom (
    // counter control from the device
    input eprgbt_pkg::eprgbt_cnt_t cnt,
    // image byte at the counter address
    output logic [7:0] data
);
    logic [13:0] addr_ff;
    // ==========
    // counter
    // steps on its own clock, not the device address, as the board counter does
    always @(posedge cnt.clk or posedge cnt.rst) begin
        if (cnt.rst) addr_ff <= 14'h0000;
        else addr_ff <= addr_ff + 14'h0001;
    end
    // only the first sixteen bytes carry code; unused bytes hold the erased value
    assign data = (addr_ff[13:4] == 10'h000) ? {4'hA, addr_ff[3:0]} : 8'h00;
endmodule

// file: sim/eprgbt_top_tb_top.sv
// self-checking bench for the eprom programming and boot mode block
`timescale 1ns/1ns
module eprgbt_top_tb_top;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic arready, rvalid, tv, pb2, pb3, pb6, cpu_ep_wr, cpu_ep_rd, cpu_vec_fetch, led_oe;
    logic m_lat, m_pul;
    logic [7:0] awaddr, araddr, cpu_ep_wdata, cpu_ep_rdata, arr_rdata, ext_data;
    logic [31:0] wdata, rdata, rd_v;
    logic [3:0] wstrb;
    logic [3:0] st [5] = '{4'b0111, 4'b1001, 4'b1011, 4'b1101, 4'b1111};
    logic [1:0] bresp, rresp, rsp;
    logic [13:0] cpu_ep_addr, vector_addr, pseudo_vec_addr, ram_entry_addr;
    logic [2:0] cpu_vec_idx;
    eprgbt_pkg::eprgbt_arr_t arr;
    eprgbt_pkg::eprgbt_cnt_t ext_cnt;
    eprgbt_pkg::eprgbt_led_t led;
    int num_errors = 0, cmp_count = 0, k, j;
    eprgbt_top #(.PULSE_CYCLES(3)) dut_u (
        .aclk, .aresetn, .ce(1'b1), .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
        .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
        .rdata, .rresp, .test_mode_voltage(tv), .port_b_bit_two(pb2), .port_b_bit_three(pb3),
        .port_b_bit_six_in(pb6), .cpu_ep_wr, .cpu_ep_rd, .cpu_ep_addr, .cpu_ep_wdata,
        .cpu_ep_rdata, .cpu_vec_fetch, .cpu_vec_idx, .vector_addr, .pseudo_vec_addr,
        .ram_entry_addr, .arr, .arr_rdata, .ext_cnt, .ext_data, .led, .led_oe);
    eprgbt_ext_eprom ext_u (.cnt(ext_cnt), .data(ext_data));
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // ==========
    // checking and closing
    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ==========
    // bus master; every task is entered just after a rising edge and left just after one, except cpu_cyc, which leaves after a falling edge
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] ws);
        logic da, dw;
        da = 1'b0;
        dw = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= ws;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(da && dw)) begin
            @(negedge aclk);
            da = da | (awvalid & awready);
            dw = dw | (wvalid & wready);
            @(posedge aclk);
            awvalid <= !da;
            wvalid <= !dw;
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        rsp = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        rd_v = rdata;
        rsp = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    // write control, step the model, read back
    task ctl(input logic [31:0] d, input logic [3:0] ws);
        wr(8'h1C, d, ws);
        chk(rsp, 2'h0);
        if (ws[0]) begin
            m_pul = d[0] & d[1] & m_lat;
            m_lat = d[1];
        end
        rd(8'h1C);
        chk(rd_v, {30'h0, m_lat, m_pul});
        chk(arr.power, m_pul);
        chk(arr.rd_en, !m_lat);
    endtask
    task rst(input logic [3:0] s);
        {tv, pb2, pb3, pb6} <= s;
        aresetn <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        m_lat = 1'b0;
        m_pul = 1'b0;
        @(posedge aclk);
    endtask
    task cpu_cyc(input logic w, input logic r);
        cpu_ep_wr <= w;
        cpu_ep_rd <= r;
        @(posedge aclk);
        cpu_ep_wr <= 1'b0;
        cpu_ep_rd <= 1'b0;
        @(negedge aclk);
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, cpu_ep_wr, cpu_ep_rd} = '0;
        {awaddr, araddr, wdata, wstrb, cpu_ep_addr, cpu_ep_wdata, arr_rdata} = '0;
        {tv, pb2, pb3, pb6, cpu_vec_fetch, cpu_vec_idx} = '0;
        k = $urandom(17885);
        @(posedge aclk);
        for (k = 0; k < 5; k++) begin
            rst(st[k]);
            rd(8'h00);
            // look away from the edge that launches the registered outputs
            @(negedge aclk);
            chk(rsp, 2'h0);
            chk(rd_v[2:0], k[2:0]);
            chk(ram_entry_addr, (k == 3) ? 14'h0081 : 14'h0000);
            chk(led_oe, (k == 1 || k == 2));
            chk(led.programming_indicator, (k == 2));
            if (k == 1 || k == 2) chk(ext_data[7:4], 4'hA);
            chk(led.verify_match_indicator, 1'b0);
            @(posedge aclk);
            for (int i = 0; i < 8; i++) begin
                cpu_vec_idx <= 3'(i);
                cpu_vec_fetch <= 1'b1;
                @(posedge aclk);
                cpu_vec_fetch <= 1'b0;
                @(negedge aclk);
                j = (i > 5) ? 5 : i;
                chk(vector_addr, (k > 0) ? 'h3FE4 + 2 * j : 'h3FF0 + 2 * i);
                chk(pseudo_vec_addr, (k > 0) ? 'hE0 + 3 * j : 0);
                @(posedge aclk);
            end
        end
        $display("test modes done");
        rst(st[0]);
        ctl(32'h3, 4'hF);
        ctl(32'hFFFFFFFF, 4'hF);
        ctl(32'h1, 4'hF);
        for (int i = 0; i < 10; i++) ctl($urandom(), 4'hE | 4'($urandom_range(0, 1)));
        ctl(32'h2, 4'hF);
        cpu_ep_addr <= 14'($urandom());
        cpu_ep_wdata <= 8'($urandom());
        arr_rdata <= 8'($urandom());
        cpu_cyc(1'b1, 1'b0);
        chk(arr.addr, cpu_ep_addr);
        chk(arr.wdata, cpu_ep_wdata);
        @(posedge aclk);
        cpu_cyc(1'b0, 1'b1);
        chk(cpu_ep_rdata, 8'h00);
        @(posedge aclk);
        ctl(32'h0, 4'hF);
        cpu_cyc(1'b0, 1'b1);
        chk(cpu_ep_rdata, arr_rdata);
        @(posedge aclk);
        wr(8'h40, 32'h3, 4'hF);
        chk(rsp, 2'h2);
        rd(8'h40);
        chk(rsp, 2'h2);
        $display("test control done");
        conclude;
    end
    initial begin
        #400000;
        num_errors++;
        conclude;
    end
endmodule
